// >>> design/pgc_top.sv
// pulse generator command interpreter and sync/video output engine
// Summary of operation
// - source command takes only internal or external
// - state command takes only single or double
// - trigger command takes only internal or external
// - timing values take ms, us, ns; default ns
// - delay sets sync to video start, single
// - double delay sets pair spacing, double state
// - query reply lists source, state, trigger, timings
// - query timings reported as integer nanoseconds
// - query omits fields not used by mode
// - sync marker is 400 ns each period
// - invalid profile raises error 14, outputs off except mod drive bypass with external source
// - external trigger pulse starts each new sequence
// - internal trigger only: invalid if rate below delay (double delay in double state) plus width
// - all timings held at 50 ns resolution
// - reset gives single pulse, internal trigger
`timescale 1ns/10ps
`default_nettype none
module pgc_top
    import pgc_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // pulse pins
    input  wire logic        i_pulse_in,
    output logic             o_sync,
    output logic             o_video,
    output logic             o_mod_drive
);
    typedef enum logic [3:0] {
        PGC_IDLE  = 4'b0001,
        PGC_DELAY = 4'b0010,
        PGC_PULSE = 4'b0100,
        PGC_GAP   = 4'b1000
    } pgc_state_t;

    // configuration
    logic              src_ext_q;
    logic              dbl_q;
    logic              trg_ext_q;
    logic [STEP_W-1:0] rate_q;
    logic [STEP_W-1:0] width_q;
    logic [STEP_W-1:0] delay_q;
    logic [STEP_W-1:0] ddelay_q;
    logic              rej_q;

    // converts a suffixed value into 50 ns steps; 0 flags a bad suffix
    function automatic logic [STEP_W:0] to_steps(input logic [31:0] w);
        logic [63:0] ns;
        logic [1:0]  sfx;
        ns  = 64'h0;
        sfx = w[NUM_SFX_LSB +: 2];
        unique case (sfx)
            SFX_NS: ns = {34'h0, w[29:0]};
            SFX_US: ns = {34'h0, w[29:0]} * {32'h0, NS_PER_US};
            SFX_MS: ns = {34'h0, w[29:0]} * {32'h0, NS_PER_MS};
            SFX_BAD: ns = 64'h0;
        endcase
        ns = ns / 64'(RES_NS);
        if (sfx == SFX_BAD || ns[63:STEP_W] != '0)
            to_steps = {1'b0, {STEP_W{1'b0}}};
        else
            to_steps = {1'b1, ns[STEP_W-1:0]};
    endfunction

    logic [STEP_W:0] conv;
    assign conv = to_steps(i_wdata);

    logic [2:0] cmd;
    logic [1:0] chr;
    assign cmd = i_wdata[CTRL_CMD_LSB +: 3];
    assign chr = i_wdata[CTRL_VAL_LSB +: 2];

    logic chr_ok;
    always_comb begin
        chr_ok = 1'b0;
        unique case (cmd)
            CMD_SOURCE:  chr_ok = (chr == CHR_INTERNAL) || (chr == CHR_EXTERNAL);
            CMD_STATE:   chr_ok = (chr == CHR_SINGLE) || (chr == CHR_DOUBLE);
            CMD_TRIGGER: chr_ok = (chr == CHR_INTERNAL) || (chr == CHR_EXTERNAL);
            default:     chr_ok = 1'b0;
        endcase
    end

    // character commands
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            src_ext_q <= 1'b0;
            dbl_q     <= 1'b0;
            trg_ext_q <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CTRL && chr_ok) begin
            if (cmd == CMD_SOURCE)
                src_ext_q <= (chr == CHR_EXTERNAL);
            if (cmd == CMD_STATE)
                dbl_q <= (chr == CHR_DOUBLE);
            if (cmd == CMD_TRIGGER)
                trg_ext_q <= (chr == CHR_EXTERNAL);
        end
    end

    // numeric commands, stored in 50 ns steps
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rate_q   <= RST_RATE;
            width_q  <= RST_WIDTH;
            delay_q  <= RST_DELAY;
            ddelay_q <= RST_DDELAY;
        end else if (i_wr && conv[STEP_W]) begin
            if (i_addr == ADDR_RATE)
                rate_q <= conv[STEP_W-1:0];
            if (i_addr == ADDR_WIDTH)
                width_q <= conv[STEP_W-1:0];
            if (i_addr == ADDR_DELAY)
                delay_q <= conv[STEP_W-1:0];
            if (i_addr == ADDR_DDELAY)
                ddelay_q <= conv[STEP_W-1:0];
        end
    end

    // sticky flag of the last write refused, cleared by the next good one
    logic wr_num;
    assign wr_num = (i_addr == ADDR_RATE) || (i_addr == ADDR_WIDTH)
                 || (i_addr == ADDR_DELAY) || (i_addr == ADDR_DDELAY);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            rej_q <= 1'b0;
        else if (i_wr && i_addr == ADDR_CTRL)
            rej_q <= !chr_ok;
        else if (i_wr && wr_num)
            rej_q <= !conv[STEP_W];
    end

    // profile check: with internal trigger period must hold delay plus width, pair must clear width
    logic [STEP_W:0] first_gap;
    logic            bad_profile;
    assign first_gap = dbl_q ? ({1'b0, ddelay_q} + {1'b0, width_q})
                             : ({1'b0, delay_q} + {1'b0, width_q});
    assign bad_profile = (!trg_ext_q && ({1'b0, rate_q} < first_gap))
                      || (dbl_q && (ddelay_q < width_q))
                      || (width_q == '0);
    logic err_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            err_q <= 1'b0;
        else
            err_q <= bad_profile;
    end

    // trigger edge detection; the pin is taken as synchronous
    logic trig_q;
    logic trig_rise;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            trig_q <= 1'b0;
        else
            trig_q <= i_pulse_in;
    end
    assign trig_rise = i_pulse_in && !trig_q;

    // timebase: one tick per 50 ns step, every RES_CYC clocks (56 ns)
    logic [7:0] pre_q;
    logic       tick;
    assign tick = (pre_q == 8'(RES_CYC - 1));
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            pre_q <= 8'h00;
        else if (tick || (trg_ext_q && trig_rise))
            pre_q <= 8'h00;
        else
            pre_q <= pre_q + 8'h01;
    end

    // period counter and pulse sequencer
    logic [STEP_W-1:0] per_q;
    logic              start;
    assign start = trg_ext_q ? trig_rise
                             : (tick && per_q == '0);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            per_q <= '0;
        else if (trg_ext_q || err_q)
            per_q <= '0;
        else if (tick)
            per_q <= (per_q == rate_q - 1'b1) ? '0 : per_q + 1'b1;
    end

    pgc_state_t        st_q;
    logic [STEP_W-1:0] cnt_q;
    logic              second_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q     <= PGC_IDLE;
            cnt_q    <= '0;
            second_q <= 1'b0;
        end else if (err_q) begin
            st_q <= PGC_IDLE;
        end else if (start) begin
            // the single delay only applies to single pulse state
            st_q     <= dbl_q ? PGC_PULSE : PGC_DELAY;
            cnt_q    <= dbl_q ? width_q : delay_q;
            second_q <= 1'b0;
        end else if (tick) begin
            unique case (st_q)
                PGC_IDLE: st_q <= PGC_IDLE;
                PGC_DELAY: begin
                    if (cnt_q <= 1) begin
                        st_q  <= PGC_PULSE;
                        cnt_q <= width_q;
                    end else
                        cnt_q <= cnt_q - 1'b1;
                end
                PGC_PULSE: begin
                    if (cnt_q <= 1) begin
                        if (dbl_q && !second_q) begin
                            st_q  <= PGC_GAP;
                            cnt_q <= ddelay_q - width_q;
                        end else
                            st_q <= PGC_IDLE;
                    end else
                        cnt_q <= cnt_q - 1'b1;
                end
                PGC_GAP: begin
                    if (cnt_q <= 1) begin
                        st_q     <= PGC_PULSE;
                        cnt_q    <= width_q;
                        second_q <= 1'b1;
                    end else
                        cnt_q <= cnt_q - 1'b1;
                end
            endcase
        end
    end

    // sync marker, fixed width
    logic [7:0] sync_cnt_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            sync_cnt_q <= 8'h00;
        else if (err_q)
            sync_cnt_q <= 8'h00;
        else if (start)
            sync_cnt_q <= 8'(SYNC_CYC);
        else if (sync_cnt_q != 8'h00)
            sync_cnt_q <= sync_cnt_q - 8'h01;
    end

    // age of the running sync marker, only for the width checks
    logic [7:0] sync_age_q;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            sync_age_q <= 8'h00;
        else if (err_q)
            sync_age_q <= 8'h00;
        else if (start)
            sync_age_q <= 8'h01;
        else if (sync_age_q != 8'h00 && sync_age_q != 8'hFF)
            sync_age_q <= sync_age_q + 8'h01;
    end

    // registered outputs
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sync      <= 1'b0;
            o_video     <= 1'b0;
            o_mod_drive <= 1'b0;
        end else begin
            o_sync      <= (sync_cnt_q != 8'h00) && !err_q;
            o_video     <= (st_q == PGC_PULSE) && !err_q;
            // external source bypasses the generator straight to the modulator
            o_mod_drive <= src_ext_q ? i_pulse_in
                                     : ((st_q == PGC_PULSE) && !err_q);
        end
    end

    // query reply: presence mask, mnemonic codes; timings read in ns
    logic [5:0] qmask;
    always_comb begin
        qmask = 6'h00;
        if (!src_ext_q) begin
            qmask[Q_STATE]   = 1'b1;
            qmask[Q_TRIGGER] = 1'b1;
            qmask[Q_RATE]    = !trg_ext_q;
            qmask[Q_WIDTH]   = 1'b1;
            qmask[Q_DELAY]   = !dbl_q;
            qmask[Q_DDELAY]  = dbl_q;
        end
    end

    function automatic logic [31:0] to_ns(input logic [STEP_W-1:0] s);
        logic [39:0] p;
        p = {16'h0, s} * 40'(RES_NS);
        to_ns = p[31:0];
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst)
            o_rdata <= 32'h0000_0000;
        else if (!i_rd)
            o_rdata <= 32'h0000_0000;
        else begin
            unique case (i_addr)
                ADDR_QUERY: o_rdata <= {20'h0, qmask,
                    dbl_q ? CHR_DOUBLE : CHR_SINGLE,
                    trg_ext_q ? CHR_EXTERNAL : CHR_INTERNAL,
                    src_ext_q ? CHR_EXTERNAL : CHR_INTERNAL};
                ADDR_RATE:   o_rdata <= to_ns(rate_q);
                ADDR_WIDTH:  o_rdata <= to_ns(width_q);
                ADDR_DELAY:  o_rdata <= to_ns(delay_q);
                ADDR_DDELAY: o_rdata <= to_ns(ddelay_q);
                ADDR_STATUS: o_rdata <= {15'h0, rej_q,
                    err_q ? ERR_PROFILE : 8'h00, 7'h0, err_q};
                default:     o_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // assertions
    a_err_kills_out: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        err_q |=> !o_sync && !o_video)
        else $error("outputs active during invalid profile");
    a_profile_flag: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!trg_ext_q && ({1'b0, rate_q} < first_gap)) |=> err_q)
        else $error("short period not flagged");
    a_sync_rise: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (start && !err_q && !bad_profile) |=> ##1 o_sync)
        else $error("sync marker did not start");
    a_sync_width: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (sync_age_q == 8'(SYNC_CYC + 1)) |-> o_sync)
        else $error("sync marker ended early");
    a_sync_end: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (sync_age_q == 8'(SYNC_CYC + 2)) |-> !o_sync)
        else $error("sync marker too long");
    a_ext_start: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (trg_ext_q && trig_rise && !err_q)
        |=> st_q == ($past(dbl_q) ? PGC_PULSE : PGC_DELAY))
        else $error("external trigger did not start sequence");
    a_bad_sfx_keep: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wr && i_addr == ADDR_RATE && i_wdata[31:30] == SFX_BAD)
        |=> $stable(rate_q) && rej_q)
        else $error("bad suffix changed rate");
    a_bad_chr_keep: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wr && i_addr == ADDR_CTRL && !chr_ok)
        |=> $stable(dbl_q) && $stable(trg_ext_q) && $stable(src_ext_q))
        else $error("bad value changed configuration");
    a_ns_default: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_wr && i_addr == ADDR_WIDTH && i_wdata[31:30] == SFX_NS
         && i_wdata[29:0] == 30'h64) |=> width_q == 24'h2)
        else $error("plain value not taken as ns");
    a_query_ext: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (i_rd && i_addr == ADDR_QUERY && src_ext_q) |=> o_rdata[13:6] == 8'h0)
        else $error("external source query lists fields");
    a_delay_load: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (start && !err_q)
        |=> cnt_q == ($past(dbl_q) ? $past(width_q) : $past(delay_q)))
        else $error("delay not loaded at start");
endmodule
`default_nettype wire

// >>> common/pgc_pkg.sv
// package for the pulse generator command block: register map, codes, timing
package pgc_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned RES_NS         = 50;
    localparam int unsigned RES_CYC        = (RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_NS        = 400;
    localparam int unsigned SYNC_CYC       = (SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned VAL_W          = 32;
    localparam int unsigned STEP_W         = 24;
    // register offsets (byte addresses)
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_RATE      = 8'h04;
    localparam logic [7:0]  ADDR_WIDTH     = 8'h08;
    localparam logic [7:0]  ADDR_DELAY     = 8'h0C;
    localparam logic [7:0]  ADDR_DDELAY    = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h14;
    localparam logic [7:0]  ADDR_QUERY     = 8'h18;
    // control word fields: command code in [2:0], character value in [5:4]
    localparam int unsigned CTRL_CMD_LSB   = 0;
    localparam int unsigned CTRL_VAL_LSB   = 4;
    localparam logic [2:0]  CMD_SOURCE     = 3'h1;
    localparam logic [2:0]  CMD_STATE      = 3'h2;
    localparam logic [2:0]  CMD_TRIGGER    = 3'h3;
    localparam logic [1:0]  CHR_INTERNAL   = 2'h1;
    localparam logic [1:0]  CHR_EXTERNAL   = 2'h2;
    localparam logic [1:0]  CHR_SINGLE     = 2'h1;
    localparam logic [1:0]  CHR_DOUBLE     = 2'h2;
    // numeric write: value in [29:0], unit suffix in [31:30]
    localparam int unsigned NUM_SFX_LSB    = 30;
    localparam logic [1:0]  SFX_NS         = 2'h0;
    localparam logic [1:0]  SFX_US         = 2'h1;
    localparam logic [1:0]  SFX_MS         = 2'h2;
    localparam logic [1:0]  SFX_BAD        = 2'h3;
    localparam logic [VAL_W-1:0] NS_PER_US = 32'h0000_03E8;
    localparam logic [VAL_W-1:0] NS_PER_MS = 32'h000F_4240;
    // status word
    localparam logic [7:0]  ERR_PROFILE    = 8'h0E;
    localparam int unsigned ST_ERR_LSB     = 8;
    localparam int unsigned ST_REJ_BIT     = 16;
    // query field presence mask bits
    localparam int unsigned Q_STATE        = 0;
    localparam int unsigned Q_TRIGGER      = 1;
    localparam int unsigned Q_RATE         = 2;
    localparam int unsigned Q_WIDTH        = 3;
    localparam int unsigned Q_DELAY        = 4;
    localparam int unsigned Q_DDELAY       = 5;
    // reset values, held in 50 ns steps
    localparam logic [STEP_W-1:0] RST_RATE   = 24'h000014;
    localparam logic [STEP_W-1:0] RST_WIDTH  = 24'h000002;
    localparam logic [STEP_W-1:0] RST_DELAY  = 24'h00000A;
    localparam logic [STEP_W-1:0] RST_DDELAY = 24'h000004;
endpackage

// >>> tb/pgc_trig_src.sv
// external trigger source that drives the pulse input pin
`timescale 1ns/10ps
`default_nettype none
module pgc_trig_src (
    // clock and control
    input  wire logic        i_clk,
    input  wire logic        i_en,
    input  wire logic [15:0] i_period,
    // trigger pin
    output logic             o_pulse
);
    logic [15:0] cnt_q;
    // held low while disabled so no stray edge restarts the output train
    always_ff @(posedge i_clk) begin
        if (!i_en) begin
            cnt_q   <= 16'h0000;
            o_pulse <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q + 16'h0001 >= i_period) ? 16'h0000
                                                      : cnt_q + 16'h0001;
            o_pulse <= (cnt_q < (i_period >> 2));
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the pulse generator command block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pgc_pkg::*;
    logic        i_ref_clk, i_nrst, i_wr, i_rd, i_pulse_in, trig_en;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, v, m;
    logic        o_sync, o_video, o_mod_drive, pprev;
    logic [15:0] trig_per;
    int bad_count, total_checks, src, st, trig, hit;
    int stp[4];
    int cyc, p_rise, s_rise, v_rise, period, sync_len, trig_lat;
    int vid_off, vid_len, vgap, vcnt, pairs;
    logic p_q, s_q, v_q;

    pgc_top pgc_top_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_pulse_in(i_pulse_in), .o_sync(o_sync),
        .o_video(o_video), .o_mod_drive(o_mod_drive));
    pgc_trig_src pgc_trig_src_inst (.i_clk(i_ref_clk), .i_en(trig_en),
        .i_period(trig_per), .o_pulse(i_pulse_in));

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // edge monitor, measured in clock cycles
    always @(posedge i_ref_clk) begin
        cyc++;
        if (i_pulse_in && !p_q) p_rise = cyc;
        if (o_sync && !s_q) begin
            period = cyc - s_rise;
            s_rise = cyc;
            trig_lat = cyc - p_rise;
            pairs = vcnt;
            vcnt = 0;
        end
        if (!o_sync && s_q) sync_len = cyc - s_rise;
        if (o_video && !v_q) begin
            if (vcnt == 1) vgap = cyc - v_rise;
            else vid_off = cyc - s_rise;
            v_rise = cyc;
            vcnt++;
        end
        if (!o_video && v_q) vid_len = cyc - v_rise;
        p_q = i_pulse_in;
        s_q = o_sync;
        v_q = o_video;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // model keeps timings in whole 50 ns steps, truncating the remainder
    task automatic setn(input int i, input int n, input int s);
        int ns;
        ns = n * ((s == 0) ? 1 : (s == 1) ? 1000 : 1000000);
        stp[i] = ns / 50;
        wr(ADDR_RATE + 8'(4 * i), {s[1:0], 30'(n)});
    endtask

    task automatic rdn(input int i);
        logic [31:0] d;
        rd(ADDR_RATE + 8'(4 * i), d);
        chk(d, 32'(stp[i] * 50));
    endtask

    task automatic setc(input int c, input int val);
        wr(ADDR_CTRL, {26'h0, val[1:0], 1'b0, c[2:0]});
        if (val == 1 || val == 2) begin
            if (c == 1) src = val;
            if (c == 2) st = val;
            if (c == 3) trig = val;
        end
    endtask

    function automatic logic [31:0] q_exp();
        logic [5:0] q;
        q = 6'h00;
        if (src == 1) begin
            q = 6'h0B;
            q[Q_RATE] = (trig == 1);
            q[Q_DELAY] = (st == 1);
            q[Q_DDELAY] = (st == 2);
        end
        return {20'h0, q, st[1:0], trig[1:0], src[1:0]};
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge i_ref_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        i_nrst = 1'b0; i_wr = 1'b0; i_rd = 1'b0;
        i_addr = 8'h00; i_wdata = 32'h0; trig_en = 1'b0;
        trig_per = 16'd300; src = 1; st = 1; trig = 1;
        stp = '{int'(RST_RATE), int'(RST_WIDTH), int'(RST_DELAY),
                int'(RST_DDELAY)};
        void'($urandom(69494));
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        for (int i = 0; i < 4; i++) rdn(i);
        rd(ADDR_QUERY, v); chk(v, q_exp());
        rd(ADDR_STATUS, v); chk(v, 32'h0);
        repeat (400) @(posedge i_ref_clk);
        chk(32'(sync_len), 32'(SYNC_CYC));
        chk(32'(period), 32'(stp[0] * RES_CYC));
        chk(32'(vid_off), 32'(stp[2] * RES_CYC));
        chk(32'(vid_len), 32'(stp[1] * RES_CYC));
        chk(32'(pairs), 32'd1);
        $display("test reset and internal timing done");
        setc(CMD_STATE, CHR_DOUBLE);
        repeat (400) @(posedge i_ref_clk);
        chk(32'(pairs), 32'd2);
        chk(32'(vgap), 32'(stp[3] * RES_CYC));
        chk(32'(vid_off), 32'd0);
        rd(ADDR_QUERY, v); chk(v, q_exp());
        setc(CMD_STATE, CHR_SINGLE);
        $display("test double pulse done");
        for (int k = 0; k < 12; k++) begin
            int i, s, n;
            i = $urandom % 4;
            s = $urandom % 3;
            n = (s == 2) ? $urandom % 50 + 1 : $urandom % 5000 + 1;
            setn(i, n, s);
            rdn(i);
        end
        setn(0, 1, 1); setn(1, 100, 0); setn(2, 500, 0); setn(3, 200, 0);
        wr(ADDR_WIDTH, {SFX_BAD, 30'd700});
        rdn(1);
        rd(ADDR_STATUS, v); chk(v & 32'h10000, 32'h10000);
        $display("test numeric values done");
        for (int c = 1; c < 4; c++) begin
            for (int val = 0; val < 4; val++) begin
                setc(c, val);
                m = (src == 1) ? 32'hFFFFFFFF : 32'h00000FC3;
                rd(ADDR_QUERY, v); chk(v & m, q_exp() & m);
            end
        end
        rd(ADDR_STATUS, v); chk(v & 32'h10000, 32'h10000);
        trig_en <= 1'b1;
        repeat (400) begin
            @(posedge i_ref_clk);
            pprev = i_pulse_in;
            #1 chk({31'h0, o_mod_drive}, {31'h0, pprev});
        end
        setc(CMD_SOURCE, CHR_INTERNAL);
        setc(CMD_STATE, CHR_SINGLE);
        repeat (700) @(posedge i_ref_clk);
        chk(32'(trig_lat), 32'd2);
        chk(32'(period), 32'(trig_per));
        chk(32'(sync_len), 32'(SYNC_CYC));
        rd(ADDR_QUERY, v); chk(v, q_exp());
        $display("test commands and external trigger done");
        trig_en <= 1'b0;
        setc(CMD_TRIGGER, CHR_INTERNAL);
        setn(0, 100, 0);
        rd(ADDR_STATUS, v); chk(v & 32'hFFFF, 32'h0E01);
        hit = 0;
        repeat (300) begin
            @(posedge i_ref_clk);
            #1 if (o_sync || o_video || o_mod_drive) hit++;
        end
        chk(32'(hit), 32'd0);
        setn(0, 1, 1);
        rd(ADDR_STATUS, v); chk(v, 32'h0);
        repeat (400) @(posedge i_ref_clk);
        chk(32'(period), 32'(stp[0] * RES_CYC));
        hit = 0;
        repeat (400) begin
            @(posedge i_ref_clk);
            #1 if (o_mod_drive !== o_video) hit++;
        end
        chk(32'(hit), 32'd0);
        setc(CMD_STATE, CHR_DOUBLE);
        setn(3, 50, 0);
        rd(ADDR_STATUS, v);
        chk(v & 32'hFFFF, 32'h0E01);
        setn(3, 200, 0);
        rd(ADDR_STATUS, v);
        chk(v, 32'h0);
        $display("test invalid profile done");
        end_of_test();
    end
endmodule
`default_nettype wire
